// ===== upg_board.sv
// Purpose: Board circuit on one 8-bit port
// Assumes: Outside drivers act only while the bench enables them
// Notes: Released line without pull-up shows inverse of outside value
`timescale 1ns/1ps
module upg_board (
  // Device side
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  // Outside drivers
  input wire logic [7:0] ext_val,
  input wire logic ext_en,
  // Pin level
  output logic [7:0] pin_i
);
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (pin_oe[b]) pin_i[b] = pin_o[b];
      else if (ext_en) pin_i[b] = ext_val[b];
      else if (pullup_en[b]) pin_i[b] = 1'b1;
      else pin_i[b] = ~ext_val[b];
    end
  end
endmodule : upg_board

// ===== upg_pin_drv.sv
// Purpose: Output mux for one 8-bit port
// Assumes: Alternate function wins over the data latch
// Notes: Registered outputs
`timescale 1ns/1ps
module upg_pin_drv (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Port controls
  input wire logic [7:0] latch,
  input wire logic [7:0] dir,
  input wire logic [7:0] alt_en,
  input wire logic [7:0] alt_out,
  input wire logic [7:0] alt_oe,
  input wire logic allow,
  // Pins
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe
);
  logic [7:0] o_ff;
  logic [7:0] oe_ff;

  for (genvar i = 0; i < 8; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        o_ff[i] <= 1'b0;
        oe_ff[i] <= 1'b0;
      end else if (alt_en[i]) begin
        o_ff[i] <= alt_out[i];
        oe_ff[i] <= alt_oe[i];
      end else begin
        o_ff[i] <= latch[i];
        oe_ff[i] <= dir[i] & allow;
      end
    end
  end

  assign pin_o = o_ff;
  assign pin_oe = oe_ff;
endmodule : upg_pin_drv

// ===== upg_pkg.sv
// Purpose: Shared constants for the upper port group block
// Assumes: AXI4-Lite register bus, 32-bit data, byte addresses
// Notes: Each register holds one value of up to 8 bits in the low bits
package upg_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_E_DATA = 8'h00;
  localparam logic [7:0] OFF_E_ANSEL = 8'h04;
  localparam logic [7:0] OFF_F_DATA = 8'h08;
  localparam logic [7:0] OFF_F_DIR = 8'h0c;
  localparam logic [7:0] OFF_G_DATA = 8'h10;
  localparam logic [7:0] OFF_G_DIR = 8'h14;
  localparam logic [7:0] OFF_G_ASSIGN = 8'h18;
  localparam logic [7:0] OFF_H_DATA = 8'h1c;
  localparam logic [7:0] OFF_H_DIR = 8'h20;
  localparam logic [7:0] OFF_H_ALT = 8'h24;
  localparam logic [7:0] OFF_J_DATA = 8'h28;
  localparam logic [7:0] OFF_J_DIR = 8'h2c;
  localparam logic [7:0] OFF_K_DATA = 8'h30;
  localparam logic [7:0] OFF_K_DIR = 8'h34;
  localparam logic [7:0] OFF_PULLUP = 8'h38;
  localparam logic [7:0] OFF_MODE = 8'h3c;
  // Pull-up assignment field positions
  localparam int PU_F_BIT = 0;
  localparam int PU_G_BIT = 1;
  localparam int PU_H_BIT = 2;
  localparam int PU_J_BIT = 3;
  localparam int PU_K_BIT = 4;
  // Mode register field positions
  localparam int MODE_EXP_BIT = 0;
  localparam int MODE_BOOT_BIT = 1;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_PULLUP = 5'h00;
  localparam logic [1:0] RST_MODE = 2'h0;
  // Pin groups
  localparam logic [7:0] G_IO_MASK = 8'h3f;
  localparam logic [7:0] TMR_ALT_MASK = 8'hf8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : upg_pkg

// ===== upg_sync.sv
// Purpose: Two-flop synchroniser for a pin bus
// Assumes: Pins are asynchronous to aclk
// Notes: First stage feeds only the second
`timescale 1ns/1ps
module upg_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : upg_sync

// ===== upg_top.sv
// Purpose: Ports E to K general-purpose logic behind AXI4-Lite
// Assumes: Alternate-function sources come from peripherals on aclk
// Notes: Pin reads pass a two-flop synchroniser
// Summary of operation
// - Analog port pins are digital inputs or converter channels; never driven.
// - Low-address port is GPIO in single chip, address low byte expanded.
// - Low-address data reads pins; latch drives when output, single or boot.
// - Low-address port pull-ups enabled from shared pull-up register.
// - Expansion port: six bidirectional lines, two input or analog lines.
// - Assignment bits pick GPIO or, expanded only, memory expansion line.
// - Expansion data reads pins; latch drives only output-configured pins.
// - Six expansion port bidirectional pins have shared-register pull-ups.
// - Select/PWM port GPIO; upper four chip selects, lower four PWM.
// - Select/PWM data reads pins; latch drives only output pins.
// - Every select/PWM pin has a shared-register pull-up enable.
// - First timer port GPIO, upper five pins shared with second timer.
// - First timer data reads pins; latch drives only output pins.
// - Output-compare pins on first timer port ignore latch writes.
// - First timer port resets to high-impedance inputs.
// - First timer port direction bit rules when alternate is off.
// - Second timer port GPIO, upper five pins shared with third timer.
// - Second timer data reads pins; latch drives only output pins.
// - Output-compare pins on second timer port ignore latch writes.
// - Second timer port resets to high-impedance inputs.
// - Second timer port direction bit rules when alternate is off.
`timescale 1ns/1ps
module upg_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog input port
  input wire logic [7:0] e_pin_i,
  output logic [7:0] e_analog_sel,
  // Low-address port
  input wire logic [7:0] f_pin_i,
  output logic [7:0] f_pin_o,
  output logic [7:0] f_pin_oe,
  output logic [7:0] f_pullup_en,
  input wire logic [7:0] addr_low,
  // Expansion port
  input wire logic [7:0] g_pin_i,
  output logic [7:0] g_pin_o,
  output logic [7:0] g_pin_oe,
  output logic [7:0] g_pullup_en,
  output logic [1:0] g_analog_sel,
  input wire logic [5:0] memory_expansion_lines,
  // Select/PWM port
  input wire logic [7:0] h_pin_i,
  output logic [7:0] h_pin_o,
  output logic [7:0] h_pin_oe,
  output logic [7:0] h_pullup_en,
  input wire logic [3:0] chip_select,
  input wire logic [3:0] pwm_out,
  // First timer port
  input wire logic [7:0] j_pin_i,
  output logic [7:0] j_pin_o,
  output logic [7:0] j_pin_oe,
  output logic [7:0] j_pullup_en,
  input wire logic [7:0] j_tmr_en,
  input wire logic [7:0] j_tmr_out,
  input wire logic [7:0] j_tmr_oe,
  // Second timer port
  input wire logic [7:0] k_pin_i,
  output logic [7:0] k_pin_o,
  output logic [7:0] k_pin_oe,
  output logic [7:0] k_pullup_en,
  input wire logic [7:0] k_tmr_en,
  input wire logic [7:0] k_tmr_out,
  input wire logic [7:0] k_tmr_oe,
  // Operating mode
  output logic expanded_mode
);
  logic [7:0] e_s, f_s, g_s, h_s, j_s, k_s;
  logic [7:0] e_ansel_ff;
  logic [7:0] f_latch_ff, f_dir_ff;
  logic [7:0] g_latch_ff, g_dir_ff, g_assign_ff;
  logic [7:0] h_latch_ff, h_dir_ff, h_alt_ff;
  logic [7:0] j_latch_ff, j_dir_ff;
  logic [7:0] k_latch_ff, k_dir_ff;
  logic [4:0] pullup_ff;
  logic [1:0] mode_ff;
  logic [7:0] aw_addr_ff;
  logic aw_have_ff;
  logic [31:0] w_data_ff;
  logic w_have_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic do_wr;
  logic wr_hit;
  logic [7:0] wb;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic exp_on, single_boot;
  logic [7:0] f_alt_en, g_alt_en, g_alt_out, h_alt_out, g_en_ok;
  logic aw_rdy_ff, w_rdy_ff, ar_rdy_ff;
  logic [7:0] g_latch_io;

  // Pin synchronisers
  upg_sync #(.W(8)) u_se (.aclk(aclk), .aresetn(aresetn), .d(e_pin_i),
    .q(e_s));
  upg_sync #(.W(8)) u_sf (.aclk(aclk), .aresetn(aresetn), .d(f_pin_i),
    .q(f_s));
  upg_sync #(.W(8)) u_sg (.aclk(aclk), .aresetn(aresetn), .d(g_pin_i),
    .q(g_s));
  upg_sync #(.W(8)) u_sh (.aclk(aclk), .aresetn(aresetn), .d(h_pin_i),
    .q(h_s));
  upg_sync #(.W(8)) u_sj (.aclk(aclk), .aresetn(aresetn), .d(j_pin_i),
    .q(j_s));
  upg_sync #(.W(8)) u_sk (.aclk(aclk), .aresetn(aresetn), .d(k_pin_i),
    .q(k_s));

  // Write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      aw_rdy_ff <= 1'b1;
      aw_addr_ff <= 8'h00;
    end else if (s_axi_awvalid && !aw_have_ff) begin
      aw_have_ff <= 1'b1;
      aw_rdy_ff <= 1'b0;
      aw_addr_ff <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_have_ff <= 1'b0;
      aw_rdy_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_ff <= 1'b0;
      w_rdy_ff <= 1'b1;
      w_data_ff <= 32'h00000000;
    end else if (s_axi_wvalid && !w_have_ff) begin
      w_have_ff <= 1'b1;
      w_rdy_ff <= 1'b0;
      w_data_ff <= s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
    end else if (do_wr) begin
      w_have_ff <= 1'b0;
      w_rdy_ff <= 1'b1;
    end
  end

  assign s_axi_awready = aw_rdy_ff;
  assign s_axi_wready = w_rdy_ff;
  assign do_wr = aw_have_ff & w_have_ff & ~bvalid_ff;
  assign wb = w_data_ff[7:0];

  // Write decode
  always_comb begin
    case (aw_addr_ff)
      upg_pkg::OFF_E_DATA, upg_pkg::OFF_E_ANSEL, upg_pkg::OFF_F_DATA,
      upg_pkg::OFF_F_DIR, upg_pkg::OFF_G_DATA, upg_pkg::OFF_G_DIR,
      upg_pkg::OFF_G_ASSIGN, upg_pkg::OFF_H_DATA, upg_pkg::OFF_H_DIR,
      upg_pkg::OFF_H_ALT, upg_pkg::OFF_J_DATA, upg_pkg::OFF_J_DIR,
      upg_pkg::OFF_K_DATA, upg_pkg::OFF_K_DIR, upg_pkg::OFF_PULLUP,
      upg_pkg::OFF_MODE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= upg_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? upg_pkg::RESP_OKAY : upg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Control registers; direction bits clear at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      e_ansel_ff <= upg_pkg::RST_BYTE;
      f_latch_ff <= upg_pkg::RST_BYTE;
      f_dir_ff <= upg_pkg::RST_BYTE;
      g_latch_ff <= upg_pkg::RST_BYTE;
      g_dir_ff <= upg_pkg::RST_BYTE;
      g_assign_ff <= upg_pkg::RST_BYTE;
      h_latch_ff <= upg_pkg::RST_BYTE;
      h_dir_ff <= upg_pkg::RST_BYTE;
      h_alt_ff <= upg_pkg::RST_BYTE;
      j_latch_ff <= upg_pkg::RST_BYTE;
      j_dir_ff <= upg_pkg::RST_BYTE;
      k_latch_ff <= upg_pkg::RST_BYTE;
      k_dir_ff <= upg_pkg::RST_BYTE;
      pullup_ff <= upg_pkg::RST_PULLUP;
      mode_ff <= upg_pkg::RST_MODE;
    end else if (do_wr) begin
      case (aw_addr_ff)
        upg_pkg::OFF_E_ANSEL: e_ansel_ff <= wb;
        upg_pkg::OFF_F_DATA: f_latch_ff <= wb;
        upg_pkg::OFF_F_DIR: f_dir_ff <= wb;
        upg_pkg::OFF_G_DATA: g_latch_ff <= wb;
        upg_pkg::OFF_G_DIR: g_dir_ff <= wb & upg_pkg::G_IO_MASK;
        upg_pkg::OFF_G_ASSIGN: g_assign_ff <= wb & upg_pkg::G_IO_MASK;
        upg_pkg::OFF_H_DATA: h_latch_ff <= wb;
        upg_pkg::OFF_H_DIR: h_dir_ff <= wb;
        upg_pkg::OFF_H_ALT: h_alt_ff <= wb;
        upg_pkg::OFF_J_DATA: j_latch_ff <= wb;
        upg_pkg::OFF_J_DIR: j_dir_ff <= wb;
        upg_pkg::OFF_K_DATA: k_latch_ff <= wb;
        upg_pkg::OFF_K_DIR: k_dir_ff <= wb;
        upg_pkg::OFF_PULLUP: pullup_ff <= wb[4:0];
        upg_pkg::OFF_MODE: mode_ff <= wb[1:0];
        default: mode_ff <= mode_ff;
      endcase
    end
  end

  // Read path
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      upg_pkg::OFF_E_DATA: rd_byte = e_s;
      upg_pkg::OFF_E_ANSEL: rd_byte = e_ansel_ff;
      upg_pkg::OFF_F_DATA: rd_byte = f_s;
      upg_pkg::OFF_F_DIR: rd_byte = f_dir_ff;
      upg_pkg::OFF_G_DATA: rd_byte = g_s;
      upg_pkg::OFF_G_DIR: rd_byte = g_dir_ff;
      upg_pkg::OFF_G_ASSIGN: rd_byte = g_assign_ff;
      upg_pkg::OFF_H_DATA: rd_byte = h_s;
      upg_pkg::OFF_H_DIR: rd_byte = h_dir_ff;
      upg_pkg::OFF_H_ALT: rd_byte = h_alt_ff;
      upg_pkg::OFF_J_DATA: rd_byte = j_s;
      upg_pkg::OFF_J_DIR: rd_byte = j_dir_ff;
      upg_pkg::OFF_K_DATA: rd_byte = k_s;
      upg_pkg::OFF_K_DIR: rd_byte = k_dir_ff;
      upg_pkg::OFF_PULLUP: rd_byte = {3'h0, pullup_ff};
      upg_pkg::OFF_MODE: rd_byte = {6'h00, mode_ff};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = ar_rdy_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      ar_rdy_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
      rresp_ff <= upg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      ar_rdy_ff <= 1'b0;
      rdata_ff <= {24'h000000, rd_byte};
      rresp_ff <= rd_hit ? upg_pkg::RESP_OKAY : upg_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
      ar_rdy_ff <= 1'b1;
    end
  end

  // Mode decode
  assign exp_on = mode_ff[upg_pkg::MODE_EXP_BIT];
  assign single_boot = ~exp_on;
  assign f_alt_en = {8{exp_on}};
  assign g_en_ok = g_assign_ff & {8{exp_on}} & upg_pkg::G_IO_MASK;
  assign g_alt_en = g_en_ok;
  assign g_alt_out = {2'h0, memory_expansion_lines};
  assign g_latch_io = g_latch_ff & upg_pkg::G_IO_MASK;
  assign h_alt_out = {chip_select, pwm_out};

  // Low-address port latch drives only in single chip or boot; expanded mode drives addr_low on all pins
  upg_pin_drv u_df (.aclk(aclk), .aresetn(aresetn), .latch(f_latch_ff),
    .dir(f_dir_ff), .alt_en(f_alt_en), .alt_out(addr_low),
    .alt_oe(8'hff), .allow(single_boot), .pin_o(f_pin_o),
    .pin_oe(f_pin_oe));

  // Expansion port; upper two lines never driven
  upg_pin_drv u_dg (.aclk(aclk), .aresetn(aresetn), .latch(g_latch_io),
    .dir(g_dir_ff), .alt_en(g_alt_en), .alt_out(g_alt_out),
    .alt_oe(upg_pkg::G_IO_MASK), .allow(1'b1), .pin_o(g_pin_o),
    .pin_oe(g_pin_oe));

  // Select/PWM port
  upg_pin_drv u_dh (.aclk(aclk), .aresetn(aresetn), .latch(h_latch_ff),
    .dir(h_dir_ff), .alt_en(h_alt_ff), .alt_out(h_alt_out),
    .alt_oe(8'hff), .allow(1'b1), .pin_o(h_pin_o),
    .pin_oe(h_pin_oe));

  // Timer ports; alternate owns only the upper five pins, where latch writes have no effect while it is enabled
  upg_pin_drv u_dj (.aclk(aclk), .aresetn(aresetn), .latch(j_latch_ff),
    .dir(j_dir_ff), .alt_en(j_tmr_en & upg_pkg::TMR_ALT_MASK),
    .alt_out(j_tmr_out), .alt_oe(j_tmr_oe), .allow(1'b1),
    .pin_o(j_pin_o), .pin_oe(j_pin_oe));

  upg_pin_drv u_dk (.aclk(aclk), .aresetn(aresetn), .latch(k_latch_ff),
    .dir(k_dir_ff), .alt_en(k_tmr_en & upg_pkg::TMR_ALT_MASK),
    .alt_out(k_tmr_out), .alt_oe(k_tmr_oe), .allow(1'b1),
    .pin_o(k_pin_o), .pin_oe(k_pin_oe));

  // Registered side outputs
  logic [7:0] e_asel_o_ff, fpu_ff, gpu_ff, hpu_ff, jpu_ff, kpu_ff;
  logic [1:0] g_asel_ff;
  logic exp_o_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      e_asel_o_ff <= 8'h00;
      g_asel_ff <= 2'h0;
      fpu_ff <= 8'h00;
      gpu_ff <= 8'h00;
      hpu_ff <= 8'h00;
      jpu_ff <= 8'h00;
      kpu_ff <= 8'h00;
      exp_o_ff <= 1'b0;
    end else begin
      e_asel_o_ff <= e_ansel_ff;
      g_asel_ff <= e_ansel_ff[7:6];
      fpu_ff <= {8{pullup_ff[upg_pkg::PU_F_BIT]}} & ~f_pin_oe;
      gpu_ff <= {8{pullup_ff[upg_pkg::PU_G_BIT]}} & upg_pkg::G_IO_MASK
        & ~g_pin_oe;
      hpu_ff <= {8{pullup_ff[upg_pkg::PU_H_BIT]}} & ~h_pin_oe;
      jpu_ff <= {8{pullup_ff[upg_pkg::PU_J_BIT]}} & ~j_pin_oe;
      kpu_ff <= {8{pullup_ff[upg_pkg::PU_K_BIT]}} & ~k_pin_oe;
      exp_o_ff <= exp_on;
    end
  end

  assign e_analog_sel = e_asel_o_ff;
  assign g_analog_sel = g_asel_ff;
  assign f_pullup_en = fpu_ff;
  assign g_pullup_en = gpu_ff;
  assign h_pullup_en = hpu_ff;
  assign j_pullup_en = jpu_ff;
  assign k_pullup_en = kpu_ff;
  assign expanded_mode = exp_o_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule : upg_top

// ===== upg_top_sva.sv
// Purpose: Concurrent checks on pins and bus of the port group
// Assumes: Sees only top-level ports
// Notes: Bound to every upg_top instance
`timescale 1ns/1ps
module upg_top_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [7:0] f_pin_o,
  input wire logic [7:0] f_pin_oe,
  input wire logic [7:0] addr_low,
  input wire logic expanded_mode,
  input wire logic [7:0] g_pin_oe,
  input wire logic [7:0] g_pullup_en,
  input wire logic [7:0] h_pin_oe,
  input wire logic [7:0] j_pin_o,
  input wire logic [7:0] j_pin_oe,
  input wire logic [7:0] j_tmr_en,
  input wire logic [7:0] j_tmr_out,
  input wire logic [7:0] j_tmr_oe,
  input wire logic [7:0] k_pin_o,
  input wire logic [7:0] k_pin_oe,
  input wire logic [7:0] k_tmr_en,
  input wire logic [7:0] k_tmr_out,
  input wire logic [7:0] k_tmr_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_hiz_a: assert property (
    $rose(aresetn) |-> (f_pin_oe | g_pin_oe | h_pin_oe | j_pin_oe | k_pin_oe)
    == 8'h00) else $error("pin driven at reset release");
  j_alt_a: assert property (
    (j_tmr_en & 8'hf8) == 8'hf8 |=> (j_pin_oe & 8'hf8) == ($past(j_tmr_oe)
    & 8'hf8) && (j_pin_o & j_pin_oe & 8'hf8) == ($past(j_tmr_out)
    & $past(j_tmr_oe) & 8'hf8)) else $error("first timer alt pins wrong");
  k_alt_a: assert property (
    (k_tmr_en & 8'hf8) == 8'hf8 |=> (k_pin_oe & 8'hf8) == ($past(k_tmr_oe)
    & 8'hf8) && (k_pin_o & k_pin_oe & 8'hf8) == ($past(k_tmr_out)
    & $past(k_tmr_oe) & 8'hf8)) else $error("second timer alt pins wrong");
  exp_addr_a: assert property (
    expanded_mode |-> f_pin_oe == 8'hff && f_pin_o == $past(addr_low))
    else $error("low-address port not on address bus");
  g_upper_a: assert property (
    g_pin_oe[7:6] == 2'b00 && g_pullup_en[7:6] == 2'b00)
    else $error("input-only expansion pins driven or pulled");
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rvalid_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  ar_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
endmodule : upg_top_sva
bind upg_top upg_top_sva u_sva (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .f_pin_o, .f_pin_oe, .addr_low, .expanded_mode, .g_pin_oe,
  .g_pullup_en, .h_pin_oe, .j_pin_o, .j_pin_oe, .j_tmr_en, .j_tmr_out,
  .j_tmr_oe, .k_pin_o, .k_pin_oe, .k_tmr_en, .k_tmr_out, .k_tmr_oe);

// ===== upg_top_tb.sv
// Purpose: Register-level test of the upper port group
// Assumes: Board model on ports F to K, timer and bus sources from here
// Notes: Pin reads checked after the synchroniser settles
`timescale 1ns/1ps
module upg_top_tb;
  localparam logic [1:0] ok = upg_pkg::RESP_OKAY;
  localparam logic [1:0] err = upg_pkg::RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, expanded_mode;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, g_analog_sel;
  logic [7:0] e_pin_i = 8'h7e, addr_low = 8'h00, e_analog_sel;
  logic [5:0] memory_expansion_lines = 6'h00;
  logic [3:0] chip_select = 4'h6, pwm_out = 4'h9;
  logic [7:0] tmr_en = 8'h00, tmr_out = 8'h00, tmr_oe = 8'h00;
  logic ext_en = 1'b1;
  logic [7:0] po[5], poe[5], ppu[5], pi[5];
  logic [7:0] ext[5] = '{8'h3c, 8'h96, 8'h5a, 8'h69, 8'he1};
  logic [7:0] msk[5] = '{8'hff, upg_pkg::G_IO_MASK, 8'hff, 8'hff, 8'hff};
  // Data offsets; direction sits one word above each
  logic [7:0] od[5] = '{upg_pkg::OFF_F_DATA, upg_pkg::OFF_G_DATA,
    upg_pkg::OFF_H_DATA, upg_pkg::OFF_J_DATA, upg_pkg::OFF_K_DATA};
  int miscompares = 0;
  int n_tests = 0;

  upg_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .e_pin_i, .e_analog_sel, .addr_low,
    .g_analog_sel, .memory_expansion_lines, .chip_select, .pwm_out,
    .expanded_mode, .f_pin_i(pi[0]), .f_pin_o(po[0]), .f_pin_oe(poe[0]),
    .f_pullup_en(ppu[0]), .g_pin_i(pi[1]), .g_pin_o(po[1]),
    .g_pin_oe(poe[1]), .g_pullup_en(ppu[1]), .h_pin_i(pi[2]),
    .h_pin_o(po[2]), .h_pin_oe(poe[2]), .h_pullup_en(ppu[2]),
    .j_pin_i(pi[3]), .j_pin_o(po[3]), .j_pin_oe(poe[3]),
    .j_pullup_en(ppu[3]), .j_tmr_en(tmr_en), .j_tmr_out(tmr_out),
    .j_tmr_oe(tmr_oe), .k_pin_i(pi[4]), .k_pin_o(po[4]), .k_pin_oe(poe[4]),
    .k_pullup_en(ppu[4]), .k_tmr_en(tmr_en), .k_tmr_out(tmr_out),
    .k_tmr_oe(tmr_oe));

  for (genvar i = 0; i < 5; i++) begin : g_brd
    upg_board u_brd (.pin_o(po[i]), .pin_oe(poe[i]), .pullup_en(ppu[i]),
      .ext_val(ext[i]), .ext_en(ext_en), .pin_i(pi[i]));
  end

  initial forever #5 aclk = ~aclk;

  task automatic report_and_stop;
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] got);
    n_tests++;
    if (got !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, x, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic axw(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] rx);
    int t;
    logic ab, wb, bb;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(negedge aclk);
      ab = s_axi_awvalid && s_axi_awready;
      wb = s_axi_wvalid && s_axi_wready;
      bb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ab) s_axi_awvalid <= 1'b0;
      if (wb) s_axi_wvalid <= 1'b0;
      if (bb && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        break;
      end
      if (bb) s_axi_bready <= 1'b1;
    end
    if (t == 50) begin
      miscompares++;
      report_and_stop();
    end else begin
      chk("bresp", {30'h0, rx}, {30'h0, r});
    end
  endtask : axw

  task automatic rdchk(input logic [7:0] a, input logic [7:0] x,
                       input logic [1:0] rx);
    int t;
    logic ab, rb;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(negedge aclk);
      ab = s_axi_arvalid && s_axi_arready;
      rb = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ab) s_axi_arvalid <= 1'b0;
      if (rb && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        break;
      end
      if (rb) s_axi_rready <= 1'b1;
    end
    if (t == 50) begin
      miscompares++;
      report_and_stop();
    end else begin
      chk("rdata", {24'h0, x}, d);
      chk("rresp", {30'h0, rx}, {30'h0, r});
    end
  endtask : rdchk

  initial begin
    logic [7:0] e;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) chk("oe_rst", 8'h00, poe[i]);
    for (int i = 0; i < 5; i++) begin
      e = 8'hc3 & msk[i];
      axw(od[i], 8'ha5, ok);
      tick(6);
      chk("oe_in", 8'h00, poe[i]);
      rdchk(od[i], ext[i], ok);
      axw(od[i] + 8'h04, 8'hc3, ok);
      tick(6);
      chk("oe", e, poe[i]);
      chk("o", 8'ha5 & e, po[i] & e);
      rdchk(od[i], (8'ha5 & e) | (ext[i] & ~e), ok);
      rdchk(od[i] + 8'h04, e, ok);
    end
    axw(upg_pkg::OFF_PULLUP, 8'h1f, ok);
    ext_en <= 1'b0;
    tick(6);
    for (int i = 0; i < 5; i++) begin
      e = 8'hc3 & msk[i];
      chk("pullup", ~e & msk[i], ppu[i]);
      rdchk(od[i], (8'ha5 & e) | (~e & (msk[i] | ~ext[i])), ok);
    end
    ext_en <= 1'b1;
    tmr_en <= 8'hf8;
    tmr_oe <= 8'hf0;
    tmr_out <= 8'h90;
    axw(upg_pkg::OFF_J_DATA, 8'h0f, ok);
    axw(upg_pkg::OFF_K_DATA, 8'h0f, ok);
    tick(4);
    for (int i = 3; i < 5; i++) begin
      chk("tmr_oe", 8'hf3, poe[i]);
      chk("tmr_o", 8'h93, po[i] & poe[i]);
    end
    tmr_en <= 8'h00;
    tick(4);
    for (int i = 3; i < 5; i++) chk("gp_o", 8'h03, po[i] & poe[i]);
    addr_low <= 8'h3c;
    memory_expansion_lines <= 6'h2a;
    axw(upg_pkg::OFF_G_ASSIGN, 8'h3f, ok);
    tick(4);
    chk("g_single", 8'h03, poe[1]);
    axw(upg_pkg::OFF_MODE, 8'h01, ok);
    tick(4);
    chk("mode", 1'b1, expanded_mode);
    chk("f_exp", 16'hff3c, {poe[0], po[0]});
    chk("g_exp", 16'h3f2a, {poe[1] & 8'h3f, po[1] & 8'h3f});
    axw(upg_pkg::OFF_MODE, 8'h02, ok);
    tick(4);
    chk("boot", 16'hc303, {poe[0], poe[1]});
    axw(upg_pkg::OFF_H_ALT, 8'hff, ok);
    axw(od[2] + 8'h04, 8'hff, ok);
    tick(4);
    chk("h_alt", 8'h69, po[2]);
    rdchk(upg_pkg::OFF_E_DATA, 8'h7e, ok);
    axw(upg_pkg::OFF_E_ANSEL, 8'hc3, ok);
    tick(2);
    chk("ansel", 10'h3c3, {g_analog_sel, e_analog_sel});
    s_axi_wstrb <= 4'he;
    axw(upg_pkg::OFF_E_ANSEL, 8'hff, ok);
    s_axi_wstrb <= 4'hf;
    rdchk(upg_pkg::OFF_E_ANSEL, 8'h00, ok);
    axw(8'h40, 8'h55, err);
    rdchk(8'h40, 8'h00, err);
    report_and_stop();
  end
endmodule : upg_top_tb
